// file: ovw_regs.sv
// Overview of operation
// - Delay code picks wait before disabling output.
// - Same code picks spacing between restart attempts.
// - Output above overvoltage threshold raises warning.
// - Output at or below undervoltage threshold warns.
// - Thresholds are mantissa times two to exponent.
// - Threshold top bits read mode register exponent.
// - Host writes eleven-bit mantissa; device uses it.
// - Response field selects ignore, continue, shutdown, hold.
// - Retry count exhausted latches output off.
`timescale 1ns/100ps
`include "ovw_defines.svh"
module ovw_regs #(
    parameter int MS_CYCLES = `OVW_MS_CYCLES
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire ovw_pkg::ovw_req_t reg_req_i,
    output logic [15:0]           reg_rdata_o,
    input  wire logic [17:0]      vout_meas_i,
    input  wire logic             ov_fault_i,
    output logic                  ov_warn_o,
    output logic                  uv_warn_o,
    output logic                  out_enable_o,
    output logic                  latched_off_o
);
    ovw_pkg::ovw_fault_act_t act_reg,   act_next;
    logic [10:0]             ov_m_reg,  ov_m_next;
    logic [10:0]             uv_m_reg,  uv_m_next;
    logic [2:0]              exp_reg,   exp_next;
    logic [15:0]             rd_reg,    rd_next;
    ovw_pkg::ovw_state_t     st_reg,    st_next;
    logic [2:0]              used_reg,  used_next;
    logic                    en_reg,    en_next;
    logic                    ovw_reg,   ovw_next;
    logic                    uvw_reg,   uvw_next;
    logic [4:0]              exp_rd;
    logic [2:0]              shamt;
    logic [17:0]             thr_ov;
    logic [17:0]             thr_uv;
    logic [11:0]             d1_ms;
    logic [11:0]             d2_ms;
    logic                    can_retry;
    logic                    t_start;
    logic [11:0]             t_ms;
    logic                    t_done;

    // Register access and read-back.
    always_comb begin
        act_next = act_reg;
        ov_m_next = ov_m_reg;
        uv_m_next = uv_m_reg;
        exp_next = exp_reg;
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                `OVW_ADDR_MODE:
                    exp_next = reg_req_i.wdata[`OVW_MODE_EXP_MSB:
                                               `OVW_MODE_EXP_LSB];
                `OVW_ADDR_FAULT_ACT:
                    act_next = reg_req_i.wdata[7:0];
                `OVW_ADDR_OV_WARN:
                    ov_m_next = reg_req_i.wdata[`OVW_MANT_MSB:
                                                `OVW_MANT_LSB];
                `OVW_ADDR_UV_WARN:
                    uv_m_next = reg_req_i.wdata[`OVW_MANT_MSB:
                                                `OVW_MANT_LSB];
                default: ;
            endcase
        end
    end

    // The exponent field is read-only and mirrors the mode register.
    assign exp_rd = {{2{exp_reg[2]}}, exp_reg};

    always_comb begin
        rd_next = 16'h0000;
        unique case (reg_req_i.addr)
            `OVW_ADDR_MODE:      rd_next = {13'h0000, exp_reg};
            `OVW_ADDR_FAULT_ACT: rd_next = {8'h00, act_reg};
            `OVW_ADDR_OV_WARN:   rd_next = {exp_rd, ov_m_reg};
            `OVW_ADDR_UV_WARN:   rd_next = {exp_rd, uv_m_reg};
            default:             rd_next = 16'h0000;
        endcase
    end

    // Measurement is in units of two to the minus four, the smallest
    // exponent, so the threshold only ever shifts left.
    assign shamt  = {~exp_reg[2], exp_reg[1:0]};
    assign thr_ov = {7'h00, ov_m_reg} << shamt;
    assign thr_uv = {7'h00, uv_m_reg} << shamt;

    always_comb begin
        ovw_next = vout_meas_i > thr_ov;
        uvw_next = vout_meas_i <= thr_uv;
    end

    // Delay tables.
    assign d1_ms = `OVW_D1_BASE_MS << act_reg.delay;
    always_comb begin
        unique case (act_reg.delay)
            3'h0: d2_ms = `OVW_D2_MS_0;
            3'h1: d2_ms = `OVW_D2_MS_1;
            3'h2: d2_ms = `OVW_D2_MS_2;
            3'h3: d2_ms = `OVW_D2_MS_3;
            3'h4: d2_ms = `OVW_D2_MS_4;
            3'h5: d2_ms = `OVW_D2_MS_5;
            3'h6: d2_ms = `OVW_D2_MS_6;
            3'h7: d2_ms = `OVW_D2_MS_7;
        endcase
    end

    assign can_retry = (act_reg.retry == `OVW_RETRY_INFINITE)
                       || (used_reg < act_reg.retry);

    // Fault response sequencer.
    always_comb begin
        st_next   = st_reg;
        used_next = used_reg;
        en_next   = en_reg;
        t_start   = 1'b0;
        t_ms      = d2_ms;
        unique case (st_reg)
            ovw_pkg::OVW_RUN: begin
                if (ov_fault_i) begin
                    unique case (act_reg.resp)
                        `OVW_RESP_IGNORE: ;
                        `OVW_RESP_CONTINUE: begin
                            st_next = ovw_pkg::OVW_DELAY1;
                            t_start = 1'b1;
                            t_ms    = d1_ms;
                        end
                        `OVW_RESP_SHUTDOWN: begin
                            en_next = 1'b0;
                            t_start = can_retry;
                            st_next = can_retry ? ovw_pkg::OVW_RETRY
                                                : ovw_pkg::OVW_LATCHED;
                        end
                        `OVW_RESP_HOLD: begin
                            en_next = 1'b0;
                            st_next = ovw_pkg::OVW_HOLD;
                        end
                    endcase
                end
            end
            ovw_pkg::OVW_DELAY1: begin
                if (!ov_fault_i) begin
                    st_next = ovw_pkg::OVW_RUN;
                end else if (t_done) begin
                    en_next = 1'b0;
                    t_start = can_retry;
                    st_next = can_retry ? ovw_pkg::OVW_RETRY
                                        : ovw_pkg::OVW_LATCHED;
                end
            end
            ovw_pkg::OVW_RETRY: begin
                if (t_done) begin
                    en_next   = 1'b1;
                    used_next = used_reg + 3'h1;
                    st_next   = ovw_pkg::OVW_RUN;
                end
            end
            ovw_pkg::OVW_HOLD: begin
                if (!ov_fault_i) begin
                    en_next = 1'b1;
                    st_next = ovw_pkg::OVW_RUN;
                end
            end
            ovw_pkg::OVW_LATCHED: begin
                en_next = 1'b0;
            end
            default: begin
                en_next = 1'b0;
                st_next = ovw_pkg::OVW_LATCHED;
            end
        endcase
        // Reprogramming the action starts a fresh retry budget.
        if (reg_req_i.wr && reg_req_i.addr == `OVW_ADDR_FAULT_ACT) begin
            used_next = 3'h0;
        end
    end

    ovw_ms_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .start_i    (t_start),
        .ms_i       (t_ms),
        .done_o     (t_done)
    );

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_reg  <= `OVW_RST_FAULT_ACT;
            ov_m_reg <= `OVW_RST_MANT;
            uv_m_reg <= `OVW_RST_MANT;
            exp_reg  <= `OVW_RST_MODE_EXP;
            rd_reg   <= 16'h0000;
            st_reg   <= ovw_pkg::OVW_RUN;
            used_reg <= 3'h0;
            en_reg   <= 1'b1;
            ovw_reg  <= 1'b0;
            uvw_reg  <= 1'b0;
        end else begin
            act_reg  <= act_next;
            ov_m_reg <= ov_m_next;
            uv_m_reg <= uv_m_next;
            exp_reg  <= exp_next;
            rd_reg   <= rd_next;
            st_reg   <= st_next;
            used_reg <= used_next;
            en_reg   <= en_next;
            ovw_reg  <= ovw_next;
            uvw_reg  <= uvw_next;
        end
    end

    assign reg_rdata_o   = rd_reg;
    assign out_enable_o  = en_reg;
    assign ov_warn_o     = ovw_reg;
    assign uv_warn_o     = uvw_reg;
    // The state is one-hot, so its top bit is the latched-off flop itself.
    assign latched_off_o = st_reg[4];

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_infinite;
        st_reg == ovw_pkg::OVW_DELAY1 && ov_fault_i && t_done
        && act_reg.retry == `OVW_RETRY_INFINITE
        |=> st_reg == ovw_pkg::OVW_RETRY;
    endproperty
    a_infinite: assert property (p_infinite)
        else $error("Infinite retry code fell into latch-off.");

    property p_d1_load;
        st_reg == ovw_pkg::OVW_RUN && ov_fault_i
        && act_reg.resp == `OVW_RESP_CONTINUE
        |-> t_start && t_ms == (12'h00a << act_reg.delay);
    endproperty
    a_d1_load: assert property (p_d1_load)
        else $error("First delay not loaded with its table value.");

    property p_d2_retry;
        st_reg == ovw_pkg::OVW_RETRY && !t_done
        |=> st_reg == ovw_pkg::OVW_RETRY && !en_reg;
    endproperty
    a_d2_retry: assert property (p_d2_retry)
        else $error("Restart came before the second delay ended.");

    property p_ov_warn;
        vout_meas_i > (18'(ov_m_reg) << (exp_reg + 3'h4)) |=> ov_warn_o;
    endproperty
    a_ov_warn: assert property (p_ov_warn)
        else $error("Overvoltage warning missing above threshold.");

    property p_uv_warn;
        vout_meas_i > (18'(uv_m_reg) << (exp_reg + 3'h4)) |=> !uv_warn_o;
    endproperty
    a_uv_warn: assert property (p_uv_warn)
        else $error("Undervoltage warning raised above threshold.");

    property p_exp_read;
        reg_req_i.addr == `OVW_ADDR_UV_WARN
        |=> reg_rdata_o[15:11] == {{2{$past(exp_reg[2])}},
                                   $past(exp_reg)};
    endproperty
    a_exp_read: assert property (p_exp_read)
        else $error("Threshold exponent does not mirror mode register.");

    property p_mant_write;
        reg_req_i.wr && reg_req_i.addr == `OVW_ADDR_OV_WARN
        ##1 reg_req_i.addr == `OVW_ADDR_OV_WARN
        |=> reg_rdata_o[10:0] == $past(reg_req_i.wdata[10:0], 2);
    endproperty
    a_mant_write: assert property (p_mant_write)
        else $error("Mantissa did not read back as written.");

    property p_ignore;
        st_reg == ovw_pkg::OVW_RUN && act_reg.resp == `OVW_RESP_IGNORE
        && en_reg |=> en_reg && st_reg == ovw_pkg::OVW_RUN;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("Ignore response still acted on a fault.");

    property p_latched;
        st_reg == ovw_pkg::OVW_LATCHED |=> latched_off_o [*3] ##0 !en_reg;
    endproperty
    a_latched: assert property (p_latched)
        else $error("Latched-off state was left before reset.");

    property p_exp_scale;
        $changed(exp_reg) && vout_meas_i > thr_ov |=> ov_warn_o;
    endproperty
    a_exp_scale: assert property (p_exp_scale)
        else $error("New exponent not applied at next comparison.");
endmodule

// file: ovw_defines.svh
`ifndef OVW_DEFINES_SVH
`define OVW_DEFINES_SVH

// Register addresses on the management bus.
`define OVW_ADDR_MODE       8'h20
`define OVW_ADDR_FAULT_ACT  8'h41
`define OVW_ADDR_OV_WARN    8'h42
`define OVW_ADDR_UV_WARN    8'h43

// Field positions.
`define OVW_EXP_MSB         15
`define OVW_EXP_LSB         11
`define OVW_MANT_MSB        10
`define OVW_MANT_LSB        0
`define OVW_MODE_EXP_MSB    2
`define OVW_MODE_EXP_LSB    0

// Reset values.
`define OVW_RST_FAULT_ACT   8'h00
`define OVW_RST_MANT        11'h000
`define OVW_RST_MODE_EXP    3'h0

// Field codes.
`define OVW_RESP_IGNORE     2'h0
`define OVW_RESP_CONTINUE   2'h1
`define OVW_RESP_SHUTDOWN   2'h2
`define OVW_RESP_HOLD       2'h3
`define OVW_RETRY_INFINITE  3'h7

// Timing: clock period and one millisecond, both in picoseconds.
`define OVW_CLK_PERIOD_PS   25000
`define OVW_MS_PS           1000000000
`define OVW_MS_CYCLES       (`OVW_MS_PS / `OVW_CLK_PERIOD_PS)

// First delay is the base doubled per code step.
`define OVW_D1_BASE_MS      12'h00a
`define OVW_D2_MS_0         12'h0fc
`define OVW_D2_MS_1         12'h22e
`define OVW_D2_MS_2         12'h39c
`define OVW_D2_MS_3         12'h4ec
`define OVW_D2_MS_4         12'h63c
`define OVW_D2_MS_5         12'h78c
`define OVW_D2_MS_6         12'h8dc
`define OVW_D2_MS_7         12'ha2c

`endif

// file: ovw_pkg.sv
package ovw_pkg;

    typedef enum logic [4:0] {
        OVW_RUN     = 5'b00001,
        OVW_DELAY1  = 5'b00010,
        OVW_RETRY   = 5'b00100,
        OVW_HOLD    = 5'b01000,
        OVW_LATCHED = 5'b10000
    } ovw_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic [15:0] wdata;
    } ovw_req_t;

    typedef struct packed {
        logic [1:0] resp;
        logic [2:0] retry;
        logic [2:0] delay;
    } ovw_fault_act_t;

endpackage

// file: ovw_ms_timer.sv
`timescale 1ns/100ps
module ovw_ms_timer #(
    parameter int MS_CYCLES = 40000
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic [11:0] ms_i,
    output logic             done_o
);
    localparam int PRE_W = $clog2(MS_CYCLES);

    logic [PRE_W-1:0] pre_reg,    pre_next;
    logic [11:0]      ms_reg,     ms_next;
    logic             active_reg, active_next;
    logic             done_reg,   done_next;

    // A new start always restarts the count from zero.
    always_comb begin
        pre_next    = pre_reg;
        ms_next     = ms_reg;
        active_next = active_reg;
        done_next   = 1'b0;
        if (start_i) begin
            pre_next    = '0;
            ms_next     = ms_i;
            active_next = 1'b1;
        end else if (active_reg) begin
            if (pre_reg == PRE_W'(MS_CYCLES - 1)) begin
                pre_next = '0;
                ms_next  = ms_reg - 12'h001;
                if (ms_reg <= 12'h001) begin
                    active_next = 1'b0;
                    done_next   = 1'b1;
                end
            end else begin
                pre_next = pre_reg + PRE_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_reg    <= '0;
            ms_reg     <= 12'h000;
            active_reg <= 1'b0;
            done_reg   <= 1'b0;
        end else begin
            pre_reg    <= pre_next;
            ms_reg     <= ms_next;
            active_reg <= active_next;
            done_reg   <= done_next;
        end
    end

    assign done_o = done_reg;
endmodule

// file: ovw_host_model.sv
`timescale 1ns/100ps
module ovw_host_model (
    input  wire logic         core_clk_i,
    input  wire logic [15:0]  rdata_i,
    output ovw_pkg::ovw_req_t req_o
);
    initial req_o = '0;

    // The host always sends a whole word, so the read-only exponent bits
    // travel too and the device must drop them.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        #2 req_o = '{addr: a, wr: 1'b1, wdata: d};
        @(posedge core_clk_i);
        #2 req_o.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk_i);
        #2 req_o.addr = a;
        @(posedge core_clk_i);
        #2 d = rdata_i;
    endtask
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
    localparam int MS = 2;
    typedef struct {string nm; logic [15:0] v;} ovw_note_t;
    logic              core_clk_i = 0;
    logic              rst_n_i = 0;
    logic              ov_fault_i = 0;
    logic [17:0]       vout_meas_i = '0;
    logic [15:0]       rdata;
    ovw_pkg::ovw_req_t req;
    logic              ov_warn, uv_warn, en, latched;
    int                err_count = 0, n_tests = 0, n, thr;
    int                seed = 32'hd010;
    int                d2[8] = '{252, 558, 924, 1260, 1596, 1932, 2268, 2604};
    ovw_note_t         q[$];
    ovw_note_t         cur;
    logic [15:0]       obs, rv;
    logic [10:0]       m;
    logic [2:0]        e3;
    event              ev;

    always #12.5 core_clk_i = ~core_clk_i;

    ovw_regs #(.MS_CYCLES(MS)) uut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .vout_meas_i(vout_meas_i),
        .ov_fault_i(ov_fault_i), .ov_warn_o(ov_warn), .uv_warn_o(uv_warn),
        .out_enable_o(en), .latched_off_o(latched));
    ovw_host_model hm (.core_clk_i(core_clk_i), .rdata_i(rdata),
        .req_o(req));

    task automatic conclude();
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The driver notes the expectation; the monitor below judges it.
    task automatic chk(input string nm, input logic [15:0] x,
                       input logic [15:0] v);
        q.push_back('{nm, x});
        obs = v;
        ->ev;
        #1;
    endtask

    always @(ev) begin
        cur = q.pop_front();
        n_tests++;
        if (cur.v !== obs) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", cur.nm, cur.v, obs);
        end
    end

    task automatic tick();
        @(posedge core_clk_i);
        #2;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] x);
        hm.rd(a, rv);
        chk($sformatf("reg %h", a), x, rv);
    endtask

    // Counts cycles until the output enable reaches lvl, bounded by lim.
    task automatic meas(input logic lvl, input int lim);
        n = 0;
        while (en !== lvl) begin
            if (n >= lim) begin
                err_count++;
                $display("[FAIL] enable wait exp %0d got timeout", lvl);
                conclude();
            end
            tick();
            n++;
        end
    endtask

    // Timer pipeline adds a cycle or so, hence the small tolerance.
    task automatic rng(input string nm, input int x);
        chk(nm, 16'(x), (n >= x && n <= x + 3) ? 16'(x) : 16'(n));
    endtask

    task automatic do_reset();
        rst_n_i = 0;
        ov_fault_i = 0;
        tick();
        tick();
        rst_n_i = 1;
    endtask

    initial begin
        repeat (5) @(posedge core_clk_i);
        #2 rst_n_i = 1;
        chk("enable", 1, en);
        chk("latched", 0, latched);
        foreach (d2[i]) begin
            if (i < 5) begin
                rchk(i == 0 ? 8'h20 : i == 4 ? 8'h55 : 8'(8'h40 + i), 0);
            end
        end
        hm.wr(8'h55, 16'hffff);
        rchk(8'h55, 16'h0000);
        hm.wr(8'h41, 16'hffff);
        rchk(8'h41, 16'h00ff);
        hm.wr(8'h20, 16'hffff);
        rchk(8'h20, 16'h0007);
        for (int e = 0; e < 8; e++) begin
            e3 = 3'(e);
            m = 11'($random(seed)) | 11'h002;
            hm.wr(8'h20, 16'(e));
            hm.wr(8'h42, {5'h1f, m});
            hm.wr(8'h43, {5'h00, m});
            rchk(8'h42, {{2{e3[2]}}, e3, m});
            rchk(8'h43, {{2{e3[2]}}, e3, m});
            thr = int'(m) << (int'($signed(e3)) + 4);
            vout_meas_i = 18'(thr);
            tick();
            chk("ov_warn", 0, ov_warn);
            chk("uv_warn", 1, uv_warn);
            vout_meas_i = 18'(thr + 1);
            tick();
            chk("ov_warn", 1, ov_warn);
            chk("uv_warn", 0, uv_warn);
        end
        // Exponent -1 to 0 doubles both thresholds with mantissas kept.
        hm.wr(8'h20, 16'h0000);
        tick();
        chk("ov_warn", 0, ov_warn);
        chk("uv_warn", 1, uv_warn);
        for (int c = 0; c < 8; c++) begin
            do_reset();
            hm.wr(8'h41, {8'h00, 2'b01, 3'b111, 3'(c)});
            ov_fault_i = 1;
            meas(0, 6000);
            rng("delay1", (10 << c) * MS);
            meas(1, 6000);
            rng("delay2", d2[c] * MS);
            chk("latched", 0, latched);
        end
        do_reset();
        hm.wr(8'h41, 16'h0088);
        ov_fault_i = 1;
        meas(0, 10);
        rng("shutdown", 1);
        meas(1, 600);
        rng("restart", 252 * MS);
        meas(0, 10);
        ov_fault_i = 0;
        repeat (20) tick();
        chk("enable", 0, en);
        chk("latched", 1, latched);
        do_reset();
        hm.wr(8'h41, 16'h0080);
        ov_fault_i = 1;
        meas(0, 10);
        tick();
        chk("latched", 1, latched);
        do_reset();
        hm.wr(8'h41, 16'h00c0);
        ov_fault_i = 1;
        meas(0, 10);
        rng("hold", 1);
        ov_fault_i = 0;
        meas(1, 10);
        rng("resume", 1);
        // A fault that clears inside the first delay must not disable.
        do_reset();
        hm.wr(8'h41, 16'h0040);
        ov_fault_i = 1;
        repeat (10) tick();
        chk("enable", 1, en);
        ov_fault_i = 0;
        repeat (30) tick();
        chk("enable", 1, en);
        chk("latched", 0, latched);
        do_reset();
        ov_fault_i = 1;
        repeat (50) tick();
        chk("enable", 1, en);
        chk("latched", 0, latched);
        conclude();
    end
endmodule
